// ==== logic/flash_protect_erase_sequencer.sv ====
// flash protection register and erase command sequencer behind an APB slave
// Notes on behaviour
// - protection register writes may only enlarge the protected region
// - protection register is loaded from the stored protection byte at reset
// - a double fault on that load leaves program flash fully protected
// - altering data in a protected program-flash area sets protection violation
// - block erase refused when any sector of that program block is protected
// - open bit picks protected ranges (1) or unprotected ranges (0)
// - high disable bit turns the range ending at the top address off
// - high size field writable only while high disable bit is set
// - low disable bit governs bottom range; low size writable only while set
// - open, high and low disable bits decode the protection function
// - high size codes give 2, 4, 8, 16 kilobytes ending at top
// - low size codes give 1, 2, 4, 8 kilobytes starting at bottom
// - code 0x08 at index 000 erases and verifies all flash
// - successful erase-all verify releases device security
// - clearing command complete launches; it sets again when erase finishes
// - erase-all: access error on bad index or mode, violation if protected
// - verify errors set the any flag; uncorrectable ones set the fatal flag
// - code 0x09 erases the block from address bits 17:16 and 15:0
// - erase-block: access error on index, mode, block or alignment fault
// - twenty registers at consecutive offsets up to the last one
// - erase-block sets violation if the selected block holds protection
`timescale 1ns/1ps
`default_nettype none

module flash_protect_erase_sequencer
  import fpes_pkg::*;
#(
  parameter int unsigned PARAM_DEPTH = 6,
  parameter logic [1:0]  DF_BLOCK    = DF_BLOCK_DEF
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [6:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic              pslverr,
  output logic [31:0]       prdata,
  // protection byte read at reset
  output logic              nvmReadReq,
  output logic [17:0]       nvmReadAddr,
  input  wire logic         nvmReadValid,
  input  wire logic [7:0]   nvmProtByte,
  input  wire logic         nvmDoubleFault,
  // mode and data-flash state
  input  wire logic         cmdAllowed,
  input  wire logic         dflashProtected,
  // write attempts from the memory controller
  input  wire logic         alterReq,
  input  wire logic [17:0]  alterAddr,
  // erase engine of the array
  output logic              eraseReq,
  output logic              eraseAll,
  output logic [1:0]        eraseBlock,
  input  wire fpes_verify_t verifyIn,
  // security state
  output logic              secured
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // address falls in a protected program-flash area
  function automatic logic addrProtected(input fpes_prot_t p, input logic [17:0] a);
    logic [18:0] hiSpan, loSpan;
    logic        inHi, inLo, inPf;
    hiSpan = HI_MIN_SIZE << p.hiSize;
    loSpan = LO_MIN_SIZE << p.loSize;
    // high disable switches the top range off
    inHi = ({1'b0, a} >= (HI_TOP_PLUS1 - hiSpan)) && !p.hiDis;
    inLo = ({1'b0, a} >= LO_BASE) && ({1'b0, a} < (LO_BASE + loSpan)) && !p.loDis;
    inPf = (a[17:16] == PF_BLOCK);
    addrProtected = p.open ? (inHi || inLo) : (inPf && !(inHi || inLo));
  endfunction : addrProtected
  // any protection at all in program flash
  function automatic logic anyProt(input fpes_prot_t p);
    anyProt = !(p.open && p.hiDis && p.loDis);
  endfunction : anyProt
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  fpes_state_t  state_q;
  fpes_prot_t   prot_q, prot_d, protWr;
  logic         command_complete_flag_q, access_error_q, protViol_q, mgAny_q, mgFatal_q, ctrlUnused_q;
  logic [2:0]   paramIdx_q;
  logic [15:0]  param_q [PARAM_DEPTH];
  logic         wrEn, rdSetup, idxValid, launch, chkAcc, chkViol;
  logic [4:0]   regIdx;
  logic [7:0]   cmdCode;
  logic [1:0]   blkSel;
  logic [15:0]  blkAddr;
  assign regIdx   = paddr[6:2];
  // write data seen through the protection field layout
  assign protWr   = fpes_prot_t'(pwdata[$bits(fpes_prot_t)-1:0]);
  assign idxValid = (regIdx <= IDX_LAST);
  // writes land at the edge where the access phase is answered
  // writes during a command ignored
  assign wrEn     = psel && penable && pready && pwrite && idxValid && command_complete_flag_q;
  assign rdSetup  = psel && !penable;
  // launch by writing one to complete flag
  assign launch   = wrEn && (regIdx == IDX_STATUS) && pwdata[ST_COMMAND_COMPLETE_FLAG]
                    && !access_error_q && !protViol_q && (state_q == S_IDLE);
  assign cmdCode  = param_q[0][15:8];
  assign blkSel   = param_q[0][1:0];
  assign blkAddr  = param_q[1];

  // ---------------------------------------------------------------
  // apb answer
  // ---------------------------------------------------------------
  // zero-wait answer, registered in the setup cycle
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= rdSetup;
      pslverr <= rdSetup && !idxValid;
      if (rdSetup && !pwrite) begin
        case (regIdx)
          IDX_CTRL:       prdata <= {30'h0000_0000, secured, ctrlUnused_q};
          IDX_PARAM_IDX:  prdata <= {29'h0000_0000, paramIdx_q};
          IDX_STATUS:     prdata <= {24'h00_0000, command_complete_flag_q, 1'b0, access_error_q, protViol_q,
                                     2'b00, mgAny_q, mgFatal_q};
          IDX_PROTECTION: prdata <= {24'h00_0000, prot_q};
          IDX_PARAM:      prdata <= (32'(paramIdx_q) < PARAM_DEPTH)
                                    ? {16'h0000, param_q[paramIdx_q]} : 32'h0000_0000;
          default:        prdata <= 32'h0000_0000;
        endcase
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // command parameter registers
  // ---------------------------------------------------------------
  // parameter index and spare control bit
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      paramIdx_q   <= 3'h0;
      ctrlUnused_q <= 1'b0;
    end else if (wrEn && regIdx == IDX_PARAM_IDX) begin
      paramIdx_q <= pwdata[2:0];
    end else if (wrEn && regIdx == IDX_CTRL) begin
      ctrlUnused_q <= pwdata[0];
    end
  end

  // parameter words, addressed through the index
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < PARAM_DEPTH; i++) begin
        param_q[i] <= 16'h0000;
      end
    end else if (wrEn && regIdx == IDX_PARAM && 32'(paramIdx_q) < PARAM_DEPTH) begin
      param_q[paramIdx_q] <= pwdata[15:0];
    end
  end

  // ---------------------------------------------------------------
  // protection register
  // ---------------------------------------------------------------
  // candidate value of a software write
  always_comb begin
    prot_d = prot_q;
    if (!prot_q.open) begin
      // unprotected ranges may only be switched off
      prot_d.hiDis = prot_q.hiDis | protWr.hiDis;
      prot_d.loDis = prot_q.loDis | protWr.loDis;
    end else if (!protWr.open) begin
      // open drops: old protected ranges must not become holes
      prot_d.open  = 1'b0;
      prot_d.hiDis = protWr.hiDis | ~prot_q.hiDis;
      prot_d.loDis = protWr.loDis | ~prot_q.loDis;
    end else begin
      // protected ranges may only be switched on
      prot_d.hiDis = prot_q.hiDis & protWr.hiDis;
      prot_d.loDis = prot_q.loDis & protWr.loDis;
    end
    // high size gated by high disable
    if (prot_q.hiDis) begin
      prot_d.hiSize = protWr.hiSize;
    end
    // low size gated by low disable
    if (prot_q.loDis) begin
      prot_d.loSize = protWr.loSize;
    end
  end

  // load at reset sequence, then software updates
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prot_q <= fpes_prot_t'(PROT_FAULT_VAL);
    end else if (state_q == S_LOAD && nvmReadValid) begin
      prot_q <= nvmDoubleFault ? fpes_prot_t'(PROT_FAULT_VAL) : fpes_prot_t'(nvmProtByte);
    end else if (wrEn && regIdx == IDX_PROTECTION) begin
      prot_q <= prot_d;
    end
  end

  // protection byte fetch request
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      nvmReadReq  <= 1'b0;
      nvmReadAddr <= 18'h00000;
    end else begin
      nvmReadReq  <= (state_q == S_LOAD) && !nvmReadValid;
      nvmReadAddr <= PROT_BYTE_ADDR;
    end
  end

  // ---------------------------------------------------------------
  // launch checks
  // ---------------------------------------------------------------
  // access error and violation found at launch
  always_comb begin
    chkAcc  = !cmdAllowed;
    chkViol = 1'b0;
    case (cmdCode)
      CMD_ERASE_ALL: begin
        chkAcc  = chkAcc || (paramIdx_q != PIDX_ALL);
        chkViol = anyProt(prot_q) || dflashProtected;
      end
      CMD_ERASE_BLOCK: begin
        chkAcc = chkAcc || (paramIdx_q != PIDX_BLOCK)
                 || (blkSel != PF_BLOCK && blkSel != DF_BLOCK)
                 || (blkSel == PF_BLOCK && (blkAddr[2:0] & PHRASE_MASK) != 3'h0)
                 || (blkSel == DF_BLOCK && blkAddr[0]);
        chkViol = (blkSel == PF_BLOCK) ? anyProt(prot_q) : dflashProtected;
      end
      default: begin
        chkAcc = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // command state machine
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q <= S_LOAD;
    end else begin
      case (state_q)
        S_LOAD:  state_q <= nvmReadValid ? S_IDLE : S_LOAD;
        S_IDLE:  state_q <= launch ? S_CHECK : S_IDLE;
        S_CHECK: state_q <= (chkAcc || chkViol) ? S_IDLE : S_WAIT;
        S_WAIT:  state_q <= verifyIn.done ? S_IDLE : S_WAIT;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // erase request to the array, held until done
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      eraseReq   <= 1'b0;
      eraseAll   <= 1'b0;
      eraseBlock <= 2'b00;
    end else if (state_q == S_CHECK && !chkAcc && !chkViol) begin
      eraseReq   <= 1'b1;
      eraseAll   <= (cmdCode == CMD_ERASE_ALL);
      eraseBlock <= blkSel;
    end else if (state_q == S_WAIT && verifyIn.done) begin
      eraseReq <= 1'b0;
    end
  end

  // command complete flag
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      command_complete_flag_q <= 1'b0;
    end else if (state_q == S_LOAD) begin
      command_complete_flag_q <= nvmReadValid;
    end else if (launch) begin
      command_complete_flag_q <= 1'b0;
    end else if (state_q == S_CHECK && (chkAcc || chkViol)) begin
      command_complete_flag_q <= 1'b1;
    end else if (state_q == S_WAIT && verifyIn.done) begin
      command_complete_flag_q <= 1'b1;
    end
  end

  // error flags: set by hardware, write one to clear when idle
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      access_error_q   <= 1'b0;
      protViol_q <= 1'b0;
    end else begin
      if (state_q == S_CHECK && chkAcc) begin
        access_error_q <= 1'b1;
      end else if (wrEn && regIdx == IDX_STATUS && pwdata[ST_ACCESS_ERROR]) begin
        access_error_q <= 1'b0;
      end
      if ((state_q == S_CHECK && chkViol && !chkAcc)
          || (alterReq && addrProtected(prot_q, alterAddr))) begin
        protViol_q <= 1'b1;
      end else if (wrEn && regIdx == IDX_STATUS && pwdata[ST_PROTECTION_VIOLATION]) begin
        protViol_q <= 1'b0;
      end
    end
  end

  // verify result flags, cleared at each launch
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mgAny_q   <= 1'b0;
      mgFatal_q <= 1'b0;
    end else if (launch) begin
      mgAny_q   <= 1'b0;
      mgFatal_q <= 1'b0;
    end else if (state_q == S_WAIT && verifyIn.done) begin
      mgAny_q   <= verifyIn.anyErr || verifyIn.fatalErr;
      mgFatal_q <= verifyIn.fatalErr;
    end
  end

  // device security
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      secured <= 1'b1;
    end else if (state_q == S_WAIT && verifyIn.done && eraseAll
                 && !verifyIn.anyErr && !verifyIn.fatalErr) begin
      secured <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // an aborted launch may set the flag again two edges on, with an error flag beside it
  AST_LAUNCH_CLEARS: assert property (
    launch |=> !command_complete_flag_q ##1 (!command_complete_flag_q || access_error_q || protViol_q))
    else $error("launch did not clear complete flag");
  AST_ABORT_NO_ERASE: assert property (
    (state_q == S_CHECK && (chkAcc || chkViol)) |=> command_complete_flag_q && !eraseReq)
    else $error("aborted command erased or stayed busy");
  AST_DONE_SETS: assert property (
    (state_q == S_WAIT && verifyIn.done) |=> command_complete_flag_q && !eraseReq)
    else $error("complete flag not set after erase");
  AST_NO_SHRINK: assert property (
    ($past(command_complete_flag_q) && !$past(prot_q.open) && command_complete_flag_q) |-> !prot_q.open)
    else $error("protection open bit reopened");
  AST_FAULT_LOAD: assert property (
    (state_q == S_LOAD && nvmReadValid && nvmDoubleFault)
    |=> prot_q == fpes_prot_t'(PROT_FAULT_VAL)) else $error("faulty load not fully protected");
  AST_LOAD_BYTE: assert property (
    (state_q == S_LOAD && nvmReadValid && !nvmDoubleFault)
    |=> prot_q == fpes_prot_t'($past(nvmProtByte))) else $error("protection byte not loaded");
  AST_BUSY_WRITE: assert property (
    (!command_complete_flag_q && psel && penable && pwrite) |=> $stable(paramIdx_q))
    else $error("register changed while command running");
  AST_ACC_ALL: assert property (
    (state_q == S_CHECK && cmdCode == CMD_ERASE_ALL && paramIdx_q != PIDX_ALL) |=> access_error_q)
    else $error("erase-all bad index not flagged");
  AST_ACC_BLOCK: assert property (
    (state_q == S_CHECK && cmdCode == CMD_ERASE_BLOCK && paramIdx_q != PIDX_BLOCK) |=> access_error_q)
    else $error("erase-block bad index not flagged");
  AST_SECURE: assert property (
    $fell(secured) |-> $past(eraseAll) && $past(state_q) == S_WAIT)
    else $error("security released without erase-all");
  AST_FATAL_ANY: assert property (
    mgFatal_q |-> mgAny_q) else $error("fatal verify flag without any flag");
endmodule : flash_protect_erase_sequencer
`default_nettype wire

// ==== pkg/fpes_pkg.sv ====
// package: register map, field layout and command codes of the flash sequencer
package fpes_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int unsigned    REG_COUNT      = 20;
  localparam logic [4:0]     IDX_LAST       = 5'h13;
  localparam logic [4:0]     IDX_CTRL       = 5'h01;
  localparam logic [4:0]     IDX_PARAM_IDX  = 5'h02;
  localparam logic [4:0]     IDX_STATUS     = 5'h06;
  localparam logic [4:0]     IDX_PROTECTION = 5'h08;
  localparam logic [4:0]     IDX_PARAM      = 5'h0A;

  // ---------------------------------------------------------------
  // status register bit positions
  // ---------------------------------------------------------------
  localparam int unsigned    ST_COMMAND_COMPLETE_FLAG   = 7;
  localparam int unsigned    ST_ACCESS_ERROR = 5;
  localparam int unsigned    ST_PROTECTION_VIOLATION = 4;
  localparam int unsigned    ST_MGANY  = 1;
  localparam int unsigned    ST_MGFAT  = 0;

  // ---------------------------------------------------------------
  // command codes, parameter indices and address layout
  // ---------------------------------------------------------------
  localparam logic [7:0]     CMD_ERASE_ALL   = 8'h08;
  localparam logic [7:0]     CMD_ERASE_BLOCK = 8'h09;
  localparam logic [2:0]     PIDX_ALL        = 3'h0;
  localparam logic [2:0]     PIDX_BLOCK      = 3'h1;
  localparam logic [1:0]     PF_BLOCK        = 2'h3;
  localparam logic [1:0]     DF_BLOCK_DEF    = 2'h1;
  localparam logic [17:0]    PROT_BYTE_ADDR  = 18'h3FF0C;
  localparam logic [18:0]    HI_TOP_PLUS1    = 19'h40000;
  localparam logic [18:0]    HI_MIN_SIZE     = 19'h00800;
  localparam logic [18:0]    LO_BASE         = 19'h38000;
  localparam logic [18:0]    LO_MIN_SIZE     = 19'h00400;
  localparam logic [2:0]     PHRASE_MASK     = 3'h7;

  // protection byte after a faulty load: open cleared, rest set
  localparam logic [7:0]     PROT_FAULT_VAL  = 8'h7F;

  // protection register layout
  typedef struct packed {
    logic       open;
    logic       reserved_nonvolatile_bit;
    logic       hiDis;
    logic [1:0] hiSize;
    logic       loDis;
    logic [1:0] loSize;
  } fpes_prot_t;

  // result of one erase/verify run from the array
  typedef struct packed {
    logic done;
    logic anyErr;
    logic fatalErr;
  } fpes_verify_t;

  // sequencer states
  typedef enum logic [2:0] {
    S_LOAD  = 3'b000,
    S_IDLE  = 3'b001,
    S_CHECK = 3'b010,
    S_WAIT  = 3'b011
  } fpes_state_t;

endpackage : fpes_pkg

// ==== tb/test_flash_protect_erase_sequencer.sv ====
// self-checking bench for the flash protection and erase sequencer
`timescale 1ns/1ps
`default_nettype none

module test_flash_protect_erase_sequencer;
  import fpes_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic         mclk, resetn, psel, penable, pwrite, pready, pslverr, errv;
  logic [6:0]   paddr;
  logic [31:0]  pwdata, prdata, rdv;
  logic         nvmReadReq, nvmReadValid, nvmDoubleFault;
  logic [17:0]  nvmReadAddr, alterAddr;
  logic [7:0]   nvmProtByte;
  logic         cmdAllowed, dflashProtected, alterReq;
  logic         eraseReq, eraseAll, secured;
  logic [1:0]   eraseBlock;
  fpes_verify_t verifyIn;
  int           bad_count, samples_checked;
  int           eraseCount = 0;
  int           eraseMark;

  flash_protect_erase_sequencer dut (
    .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .nvmReadReq(nvmReadReq), .nvmReadAddr(nvmReadAddr), .nvmReadValid(nvmReadValid),
    .nvmProtByte(nvmProtByte), .nvmDoubleFault(nvmDoubleFault), .cmdAllowed(cmdAllowed),
    .dflashProtected(dflashProtected), .alterReq(alterReq), .alterAddr(alterAddr),
    .eraseReq(eraseReq), .eraseAll(eraseAll), .eraseBlock(eraseBlock),
    .verifyIn(verifyIn), .secured(secured)
  );

  // ---------------------------------------------------------------
  // clock, erase monitor and watchdog
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  // counts cycles with an erase request; a refused launch must add none
  always @(posedge mclk) begin
    if (eraseReq === 1'h1) eraseCount <= eraseCount + 1;
  end

  initial begin
    #500000;
    bad_count++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer, held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [4:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= {idx, 2'h0};
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'h1;
    // answer and read data are taken at the edge where pready is seen
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) chk("pready", 32'h1, 32'h0);
    rdv     = prdata;
    errv    = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [4:0] idx, input logic [31:0] d);
    apb(1'h1, idx, d);
  endtask : wr

  task automatic rdchk(input logic [4:0] idx, input logic [31:0] exp, input string what);
    apb(1'h0, idx, 32'h0);
    chk(what, exp, rdv);
  endtask : rdchk

  // reset, then serve the protection byte fetch
  task automatic rst(input logic [7:0] b, input logic fault);
    int n;
    n = 0;
    @(posedge mclk);
    resetn <= 1'h0;
    repeat (2) @(posedge mclk);
    resetn <= 1'h1;
    do begin
      @(negedge mclk);
      n++;
    end while (nvmReadReq !== 1'h1 && n < 20);
    chk("nvmReadAddr", 32'h3FF0C, 32'(nvmReadAddr));
    @(posedge mclk);
    nvmReadValid   <= 1'h1;
    nvmProtByte    <= b;
    nvmDoubleFault <= fault;
    @(posedge mclk);
    nvmReadValid   <= 1'h0;
    nvmDoubleFault <= 1'h0;
    rdchk(IDX_STATUS, 32'h80, "status after load");
  endtask : rst

  task automatic cmd(input logic [7:0] code, input logic [1:0] blk, input logic [2:0] pidx,
                     input logic [15:0] addr);
    wr(IDX_PARAM_IDX, 32'h0);
    wr(IDX_PARAM, {16'h0, code, 6'h0, blk});
    wr(IDX_PARAM_IDX, 32'h1);
    wr(IDX_PARAM, {16'h0, addr});
    wr(IDX_PARAM_IDX, {29'h0, pidx});
    eraseMark = eraseCount;
    wr(IDX_STATUS, 32'h80);
  endtask : cmd

  // a launch that must be refused with no erase at all
  task automatic refuse(input logic [7:0] code, input logic [1:0] blk, input logic [2:0] pidx,
                        input logic [15:0] addr, input logic [31:0] exp);
    cmd(code, blk, pidx, addr);
    repeat (3) @(posedge mclk);
    rdchk(IDX_STATUS, exp, "refused status");
    chk("erase started", 32'h0, 32'(eraseCount - eraseMark));
    wr(IDX_STATUS, 32'h30);
  endtask : refuse

  // a launch that runs, then finishes with the given verify result
  task automatic run_ok(input logic [7:0] code, input logic [1:0] blk, input logic [2:0] pidx,
                        input logic [15:0] addr, input logic any, input logic fat,
                        input logic all, input logic [31:0] exp);
    int n;
    n = 0;
    cmd(code, blk, pidx, addr);
    do begin
      @(negedge mclk);
      n++;
    end while (eraseReq !== 1'h1 && n < 20);
    chk("eraseReq", 32'h1, 32'(eraseReq));
    chk("eraseAll", 32'(all), 32'(eraseAll));
    if (!all) chk("eraseBlock", 32'(blk), 32'(eraseBlock));
    wr(IDX_PROTECTION, 32'h0);
    rdchk(IDX_STATUS, 32'h0, "busy status");
    @(posedge mclk);
    verifyIn <= '{1'h1, any, fat};
    @(posedge mclk);
    verifyIn <= '0;
    repeat (2) @(posedge mclk);
    rdchk(IDX_STATUS, exp, "done status");
    rdchk(IDX_PROTECTION, 32'hFF, "busy write ignored");
  endtask : run_ok

  task automatic alter(input logic [17:0] a, input logic v);
    @(posedge mclk);
    alterReq  <= 1'h1;
    alterAddr <= a;
    @(posedge mclk);
    alterReq <= 1'h0;
    rdchk(IDX_STATUS, {24'h0, 3'h4, v, 4'h0}, "violation");
    wr(IDX_STATUS, 32'h10);
  endtask : alter

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    resetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 7'h0;
    pwdata = 32'h0;
    nvmReadValid = 1'h0;
    nvmProtByte = 8'h0;
    nvmDoubleFault = 1'h0;
    cmdAllowed = 1'h1;
    dflashProtected = 1'h0;
    alterReq = 1'h0;
    alterAddr = 18'h0;
    verifyIn = '0;
    bad_count = 0;
    samples_checked = 0;
    rst(8'h00, 1'h1);
    rdchk(IDX_PROTECTION, 32'h7F, "fault load");
    alter(18'h3A000, 1'h1);
    refuse(8'h08, 2'h0, 3'h0, 16'h0, 32'h90);
    apb(1'h0, 5'h14, 32'h0);
    chk("unmapped slverr", 32'h1, 32'(errv));
    chk("unmapped data", 32'h0, rdv);
    apb(1'h0, 5'h13, 32'h0);
    chk("last slverr", 32'h0, 32'(errv));
    rst(8'hFF, 1'h0);
    rdchk(IDX_PROTECTION, 32'hFF, "loaded byte");
    wr(IDX_PROTECTION, 32'hEF);
    rdchk(IDX_PROTECTION, 32'hEF, "hi size free");
    wr(IDX_PROTECTION, 32'hCF);
    rdchk(IDX_PROTECTION, 32'hCF, "hi enable");
    wr(IDX_PROTECTION, 32'hEF);
    rdchk(IDX_PROTECTION, 32'hCF, "shrink refused");
    wr(IDX_PROTECTION, 32'hDF);
    rdchk(IDX_PROTECTION, 32'hCF, "hi size locked");
    wr(IDX_PROTECTION, 32'hCA);
    rdchk(IDX_PROTECTION, 32'hCA, "lo range");
    alter(18'h3EFFF, 1'h0);
    alter(18'h3F000, 1'h1);
    alter(18'h38FFF, 1'h1);
    alter(18'h39000, 1'h0);
    refuse(8'h09, 2'h3, 3'h1, 16'h0, 32'h90);
    rst(8'hFF, 1'h0);
    refuse(8'h08, 2'h0, 3'h1, 16'h0, 32'hA0);
    refuse(8'h09, 2'h3, 3'h0, 16'h0, 32'hA0);
    refuse(8'h09, 2'h0, 3'h1, 16'h0, 32'hA0);
    refuse(8'h09, 2'h3, 3'h1, 16'h0004, 32'hA0);
    refuse(8'h09, 2'h1, 3'h1, 16'h0001, 32'hA0);
    refuse(8'h07, 2'h0, 3'h0, 16'h0, 32'hA0);
    @(posedge mclk);
    cmdAllowed <= 1'h0;
    refuse(8'h08, 2'h0, 3'h0, 16'h0, 32'hA0);
    refuse(8'h09, 2'h3, 3'h1, 16'h0, 32'hA0);
    @(posedge mclk);
    cmdAllowed      <= 1'h1;
    dflashProtected <= 1'h1;
    refuse(8'h08, 2'h0, 3'h0, 16'h0, 32'h90);
    @(posedge mclk);
    dflashProtected <= 1'h0;
    run_ok(8'h09, 2'h1, 3'h1, 16'h0002, 1'h1, 1'h1, 1'h0, 32'h83);
    run_ok(8'h09, 2'h3, 3'h1, 16'h0008, 1'h1, 1'h0, 1'h0, 32'h82);
    chk("secured before", 32'h1, 32'(secured));
    run_ok(8'h08, 2'h0, 3'h0, 16'h0, 1'h0, 1'h0, 1'h1, 32'h80);
    chk("secured after", 32'h0, 32'(secured));
    wrap_up();
  end

endmodule : test_flash_protect_erase_sequencer

`default_nettype wire
